// [pdm_mic_pkg.sv]
// Shared constants, register map and sample types of the stereo PDM microphone input.
// Assumes a 200 MHz system clock and a 32-bit APB register bus.
package pdm_mic_pkg;
  // Register indices; the byte address is four times the index.
  localparam int IDX_OVERSAMPLE = 'h0A;
  localparam int IDX_POWER_SIX = 'h12;
  localparam int IDX_VOL_LEFT = 'h24;
  localparam int IDX_VOL_RIGHT = 'h25;
  localparam int IDX_IF_CTRL = 'h27;
  localparam int IDX_CLK_PIN = 'h28;
  localparam int IDX_STATUS = 'h29;
  localparam int ADDR_W = 8;
  localparam logic [ADDR_W-1:0] ADDR_OVERSAMPLE = ADDR_W'(IDX_OVERSAMPLE * 4);
  localparam logic [ADDR_W-1:0] ADDR_POWER_SIX = ADDR_W'(IDX_POWER_SIX * 4);
  localparam logic [ADDR_W-1:0] ADDR_VOL_LEFT = ADDR_W'(IDX_VOL_LEFT * 4);
  localparam logic [ADDR_W-1:0] ADDR_VOL_RIGHT = ADDR_W'(IDX_VOL_RIGHT * 4);
  localparam logic [ADDR_W-1:0] ADDR_IF_CTRL = ADDR_W'(IDX_IF_CTRL * 4);
  localparam logic [ADDR_W-1:0] ADDR_CLK_PIN = ADDR_W'(IDX_CLK_PIN * 4);
  localparam logic [ADDR_W-1:0] ADDR_STATUS = ADDR_W'(IDX_STATUS * 4);
  // Field positions.
  localparam int OSR_BIT = 0;
  localparam int LEFT_EN_BIT = 1;
  localparam int RIGHT_EN_BIT = 0;
  localparam int PDM_EN_BIT = 12;
  localparam int PIN_SEL_BIT = 11;
  localparam int COMMIT_BIT = 8;
  localparam int CLK_PIN_BIT = 0;
  localparam int ST_OVERRUN_BIT = 0;
  localparam int ST_EMPTY_BIT = 1;
  localparam int ST_ACTIVE_BIT = 2;
  // Reset values and gain codes.
  localparam logic OSR_RESET = 1'b1;
  localparam logic [7:0] GAIN_RESET = 8'hC0;
  localparam logic [7:0] GAIN_MUTE = 8'h00;
  localparam logic [7:0] GAIN_MAX = 8'hEF;
  localparam int GAIN_UNITY_SHIFT = 12;
  // Linear mantissa of 0.375 dB steps in Q8; sixteen steps make one octave.
  localparam logic [8:0] GAIN_MANTISSA [16] = '{9'h100, 9'h10B, 9'h117, 9'h122,
    9'h12F, 9'h13C, 9'h149, 9'h157, 9'h166, 9'h175, 9'h185, 9'h195, 9'h1A6, 9'h1B8,
    9'h1CB, 9'h1DF};
  // Timing: bit clock rate in Hz, converted to system clock cycles.
  localparam int SYS_CLK_HZ = 200_000_000;
  localparam int PDM_CLK_HZ = 2_500_000;
  localparam int HALF_CYCLES = SYS_CLK_HZ / (2 * PDM_CLK_HZ);
  localparam int MID_CYCLES = HALF_CYCLES / 2;
  localparam int OVERSAMPLE = 64;
  localparam int FIFO_DEPTH = 16;
  // One stereo sample pair.
  typedef struct packed {
    logic signed [15:0] left;
    logic signed [15:0] right;
  } stereo_sample_t;
  typedef logic [7:0] gain_code_t;
endpackage : pdm_mic_pkg

// [sample_fifo.sv]
// Synchronous FIFO with valid/ready on both sides.
// Assumes one clock; depth is a power of two.
`timescale 1ns/1ps
module sample_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 16
) (
  // Clock and reset.
  input wire logic clock,
  input wire logic rst_n,
  // Filling side.
  input wire logic inValid,
  output logic inReady,
  input wire logic [WIDTH-1:0] inData,
  // Draining side.
  output logic outValid,
  input wire logic outReady,
  output logic [WIDTH-1:0] outData
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wrPtr_r;
  logic [AW:0] rdPtr_r;
  wire full = (wrPtr_r[AW] != rdPtr_r[AW]) && (wrPtr_r[AW-1:0] == rdPtr_r[AW-1:0]);
  wire empty = (wrPtr_r == rdPtr_r);
  wire push = inValid && !full;
  wire pop = outReady && !empty;

  // Flags and read data come straight from the pointers.
  assign inReady = !full;
  assign outValid = !empty;
  assign outData = mem[rdPtr_r[AW-1:0]];

  // Storage has no reset; only the pointers define the contents.
  always_ff @(posedge clock) begin
    if (push) begin
      mem[wrPtr_r[AW-1:0]] <= inData;
    end
  end

  // Pointer update.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      wrPtr_r <= '0;
      rdPtr_r <= '0;
    end else begin
      wrPtr_r <= wrPtr_r + (AW+1)'(push);
      rdPtr_r <= rdPtr_r + (AW+1)'(pop);
    end
  end

  property p_fifo_bound;
    @(posedge clock) disable iff (!rst_n) (AW+1)'(wrPtr_r - rdPtr_r) <= (AW+1)'(DEPTH);
  endproperty
  a_fifo_bound: assert property (p_fifo_bound) else $error("FIFO occupancy exceeds depth.");
endmodule : sample_fifo

// [pdm_gain_scale.sv]
// One channel of digital volume: 0.375 dB steps, mute at code zero.
// Assumes a signed 8-bit decimated sample and a code held stable by the caller.
`timescale 1ns/1ps
module pdm_gain_scale
  import pdm_mic_pkg::*;
(
  // Clock and reset.
  input wire logic clock,
  input wire logic rst_n,
  // Sample in.
  input wire logic inValid,
  input wire logic signed [7:0] inSample,
  input wire gain_code_t gainCode,
  // Scaled sample out.
  output logic outValid,
  output logic signed [15:0] outSample
);
  // Codes above the top step all give the top gain.
  wire gain_code_t clamped = (gainCode > GAIN_MAX) ? GAIN_MAX : gainCode;
  wire logic [8:0] mantissa = GAIN_MANTISSA[clamped[3:0]];
  wire logic signed [17:0] product = inSample * $signed({1'b0, mantissa});
  wire logic signed [31:0] wide = 32'(product);
  wire logic signed [31:0] shifted = (wide <<< clamped[7:4]) >>> GAIN_UNITY_SHIFT;
  // Saturate rather than wrap, since a wrap is an audible click.
  wire logic signed [15:0] saturated = (shifted > 32'sd32767) ? 16'sh7FFF :
    (shifted < -32'sd32768) ? -16'sh8000 : shifted[15:0];
  wire logic signed [15:0] scaled = (gainCode == GAIN_MUTE) ? 16'sh0000 : saturated;

  // Output register.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      outValid <= 1'b0;
      outSample <= '0;
    end else begin
      outValid <= inValid;
      outSample <= inValid ? scaled : outSample;
    end
  end

  property p_mute_zero;
    @(posedge clock) disable iff (!rst_n) (inValid && gainCode == GAIN_MUTE) |=> outSample == 0;
  endproperty
  a_mute_zero: assert property (p_mute_zero) else $error("Muted channel gave a nonzero sample.");
endmodule : pdm_gain_scale

// [stereo_pdm_mic_input.sv]
// Stereo PDM microphone receiver with APB registers, bit clock output and volume.
// Assumes an APB master on the same clock and microphones on the shared pins.
`timescale 1ns/1ps
module stereo_pdm_mic_input
  import pdm_mic_pkg::*;
#(
  parameter int HALF = HALF_CYCLES,
  parameter int DEPTH = FIFO_DEPTH
) (
  // Clock and reset.
  input wire logic clock,
  input wire logic rst_n,
  // APB slave.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Microphone pins.
  input wire logic pdmDataPinA,
  input wire logic pdmDataPinB,
  output logic pdmBitClock,
  // Analogue path samples, used while the microphone interface is off.
  input wire logic analogValid,
  output logic analogReady,
  input wire stereo_sample_t analogSample,
  // Audio processing input stream.
  output logic audioValid,
  input wire logic audioReady,
  output stereo_sample_t audioSample
);
  // Register state.
  logic osrSel_r;
  logic leftEn_r;
  logic rightEn_r;
  logic pdmEnable_r;
  logic pinSel_r;
  logic clkPinEn_r;
  logic overrun_r;
  gain_code_t pendGain_r [2];
  gain_code_t applGain_r [2];
  // APB decode.
  wire apbAccess = psel && penable && pready;
  wire apbWrite = apbAccess && pwrite;
  wire hitOsr = (paddr == ADDR_OVERSAMPLE);
  wire hitPwr = (paddr == ADDR_POWER_SIX);
  wire hitVolL = (paddr == ADDR_VOL_LEFT);
  wire hitVolR = (paddr == ADDR_VOL_RIGHT);
  wire hitCtrl = (paddr == ADDR_IF_CTRL);
  wire hitClk = (paddr == ADDR_CLK_PIN);
  wire hitStat = (paddr == ADDR_STATUS);
  wire mapped = hitOsr | hitPwr | hitVolL | hitVolR | hitCtrl | hitClk | hitStat;
  wire commit = apbWrite && (hitVolL || hitVolR) && pwdata[COMMIT_BIT];
  wire logic fifoEmpty;
  wire logic [31:0] readMux = hitOsr ? 32'(osrSel_r) << OSR_BIT :
    hitPwr ? (32'(leftEn_r) << LEFT_EN_BIT) | (32'(rightEn_r) << RIGHT_EN_BIT) :
    hitVolL ? 32'(pendGain_r[0]) :
    hitVolR ? 32'(pendGain_r[1]) :
    hitCtrl ? (32'(pdmEnable_r) << PDM_EN_BIT) | (32'(pinSel_r) << PIN_SEL_BIT) :
    hitClk ? 32'(clkPinEn_r) << CLK_PIN_BIT :
    hitStat ? (32'(overrun_r) << ST_OVERRUN_BIT) | (32'(fifoEmpty) << ST_EMPTY_BIT) |
      (32'(pdmEnable_r) << ST_ACTIVE_BIT) : 32'h0000_0000;

  // One wait state: pready rises in the second access cycle and drops after.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      pready <= 1'b0;
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready <= psel && penable && !pready;
      prdata <= (psel && penable && !pready && !pwrite) ? readMux : 32'h0000_0000;
      pslverr <= psel && penable && !pready && !mapped;
    end
  end

  // Control registers; oversample bit comes up at its reserved value.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      osrSel_r <= OSR_RESET;
      leftEn_r <= 1'b0;
      rightEn_r <= 1'b0;
      pdmEnable_r <= 1'b0;
      pinSel_r <= 1'b0;
      clkPinEn_r <= 1'b0;
    end else if (apbWrite) begin
      if (hitOsr) osrSel_r <= pwdata[OSR_BIT];
      if (hitPwr) leftEn_r <= pwdata[LEFT_EN_BIT];
      if (hitPwr) rightEn_r <= pwdata[RIGHT_EN_BIT];
      if (hitCtrl) pdmEnable_r <= pwdata[PDM_EN_BIT];
      if (hitCtrl) pinSel_r <= pwdata[PIN_SEL_BIT];
      if (hitClk) clkPinEn_r <= pwdata[CLK_PIN_BIT];
    end
  end

  // Synchronizer, bit clock and per-channel state.
  logic sync1_r [2];
  logic sync2_r [2];
  wire logic [1:0] pinsIn = {pdmDataPinB, pdmDataPinA};
  logic [$clog2(HALF)-1:0] phaseCnt_r;
  // The midpoint follows HALF itself, so a shortened phase still samples in its middle.
  localparam int MID = HALF / 2;
  // The pair leaves one cycle after the frame's last right sample, so that sample counts.
  logic frameDone_r;
  logic [$clog2(OVERSAMPLE)-1:0] frameCnt_r;
  logic [$clog2(OVERSAMPLE):0] ones_r [2];
  wire logic [1:0] chanEn = {rightEn_r, leftEn_r};
  wire logic selData = pinSel_r ? sync2_r[1] : sync2_r[0];
  wire runClock = pdmEnable_r && clkPinEn_r;
  wire phaseEnd = runClock && (phaseCnt_r == ($clog2(HALF))'(HALF - 1));
  wire sampleTick = runClock && (phaseCnt_r == ($clog2(HALF))'(MID));
  // The reserved oversample setting gives no valid decimation, so output stays idle.
  wire decimating = sampleTick && !osrSel_r;
  wire frameEnd = decimating && !pdmBitClock &&
    (frameCnt_r == ($clog2(OVERSAMPLE))'(OVERSAMPLE - 1));
  logic [1:0] scaledValid;
  logic signed [15:0] scaled [2];

  genvar ch;
  generate
    for (ch = 0; ch < 2; ch++) begin : g_chan
      // Two flops per pin; only the second is read downstream.
      always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
          sync1_r[ch] <= 1'b0;
          sync2_r[ch] <= 1'b0;
        end else begin
          sync1_r[ch] <= pinsIn[ch];
          sync2_r[ch] <= sync1_r[ch];
        end
      end
      // Channel 0 (left) takes high-phase samples, channel 1 (right) low-phase ones.
      wire myPhase = (pdmBitClock == (ch == 0));
      wire logic [$clog2(OVERSAMPLE):0] onesNxt = frameDone_r ? '0 :
        (decimating && myPhase) ? ones_r[ch] + ($clog2(OVERSAMPLE)+1)'(selData) : ones_r[ch];
      always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
          ones_r[ch] <= '0;
        end else begin
          ones_r[ch] <= chanEn[ch] ? onesNxt : '0;
        end
      end
      // Density of ones maps to a signed sample centred on zero.
      wire logic signed [7:0] pcm = chanEn[ch] ?
        $signed(8'(ones_r[ch] + ($clog2(OVERSAMPLE)+1)'(ones_r[ch])) - 8'(OVERSAMPLE)) : 8'sh00;
      pdm_gain_scale u_gain (
        .clock(clock),
        .rst_n(rst_n),
        .inValid(frameDone_r),
        .inSample(pcm),
        .gainCode(applGain_r[ch]),
        .outValid(scaledValid[ch]),
        .outSample(scaled[ch])
      );
      // A commit moves both pending codes at once, including the one being written.
      wire hitMine = (ch == 0) ? hitVolL : hitVolR;
      wire gain_code_t pendNxt = (apbWrite && hitMine) ? pwdata[7:0] : pendGain_r[ch];
      always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
          pendGain_r[ch] <= GAIN_RESET;
          applGain_r[ch] <= GAIN_RESET;
        end else begin
          pendGain_r[ch] <= pendNxt;
          applGain_r[ch] <= commit ? pendNxt : applGain_r[ch];
        end
      end
    end
  endgenerate

  // Bit clock divider; the output stays low whenever the interface is off.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      phaseCnt_r <= '0;
      pdmBitClock <= 1'b0;
      frameCnt_r <= '0;
      frameDone_r <= 1'b0;
    end else if (!runClock) begin
      phaseCnt_r <= '0;
      pdmBitClock <= 1'b0;
      frameCnt_r <= '0;
      frameDone_r <= 1'b0;
    end else begin
      frameDone_r <= frameEnd;
      phaseCnt_r <= phaseEnd ? '0 : phaseCnt_r + 1'b1;
      pdmBitClock <= phaseEnd ? !pdmBitClock : pdmBitClock;
      frameCnt_r <= (decimating && !pdmBitClock) ? frameCnt_r + 1'b1 : frameCnt_r;
    end
  end

  // Source select: microphone pairs or analogue samples feed the FIFO.
  stereo_sample_t pend_r;
  logic pendValid_r;
  wire logic fifoInReady;
  wire fifoInValid = pdmEnable_r ? pendValid_r : analogValid;
  wire stereo_sample_t fifoInData = pdmEnable_r ? pend_r : analogSample;
  wire pairReady = scaledValid[0];
  wire drained = pendValid_r && fifoInReady;
  // The microphones cannot be stalled, so a full FIFO loses a pair and flags it.
  wire lostPair = pairReady && pendValid_r && !fifoInReady;
  wire clearOverrun = apbWrite && hitStat && pwdata[ST_OVERRUN_BIT];
  assign analogReady = !pdmEnable_r && fifoInReady;

  // Holding register for one scaled pair while the FIFO is full.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      pend_r <= '0;
      pendValid_r <= 1'b0;
      overrun_r <= 1'b0;
    end else begin
      pend_r <= (pairReady && !lostPair) ? {scaled[0], scaled[1]} : pend_r;
      pendValid_r <= pdmEnable_r && ((pairReady && !lostPair) || (pendValid_r && !drained));
      overrun_r <= lostPair || (overrun_r && !clearOverrun);
    end
  end

  sample_fifo #(
    .WIDTH($bits(stereo_sample_t)),
    .DEPTH(DEPTH)
  ) u_fifo (
    .clock(clock),
    .rst_n(rst_n),
    .inValid(fifoInValid),
    .inReady(fifoInReady),
    .inData(fifoInData),
    .outValid(audioValid),
    .outReady(audioReady),
    .outData(audioSample)
  );
  assign fifoEmpty = !audioValid;

  property p_clock_idle;
    @(posedge clock) disable iff (!rst_n) !pdmEnable_r |=> !pdmBitClock;
  endproperty
  a_clock_idle: assert property (p_clock_idle) else $error("Bit clock moved while off.");
  property p_clock_period;
    @(posedge clock) disable iff (!rst_n)
      $changed(pdmBitClock) && $past(runClock) |-> $past(phaseCnt_r) == HALF - 1;
  endproperty
  a_clock_period: assert property (p_clock_period) else $error("Bit clock half period wrong.");
  property p_pin_path;
    @(posedge clock) disable iff (!rst_n)
      $past(rst_n, 2) |-> selData == (pinSel_r ? $past(pdmDataPinB, 2) : $past(pdmDataPinA, 2));
  endproperty
  a_pin_path: assert property (p_pin_path) else $error("Data pin path wrong.");
  property p_mid_sample;
    @(posedge clock) disable iff (!rst_n)
      sampleTick |-> phaseCnt_r == MID && pdmBitClock == $past(pdmBitClock, 2);
  endproperty
  a_mid_sample: assert property (p_mid_sample) else $error("Sample not at mid phase.");
  property p_chan_off;
    @(posedge clock) disable iff (!rst_n) !leftEn_r ##1 !leftEn_r |-> ones_r[0] == 0;
  endproperty
  a_chan_off: assert property (p_chan_off) else $error("Disabled left channel ran.");
  property p_commit_both;
    @(posedge clock) disable iff (!rst_n)
      commit |=> applGain_r[0] == pendGain_r[0] && applGain_r[1] == pendGain_r[1];
  endproperty
  a_commit_both: assert property (p_commit_both) else $error("Commit did not apply both.");
  property p_store_only;
    @(posedge clock) disable iff (!rst_n)
      !commit |=> applGain_r[0] == $past(applGain_r[0]) && applGain_r[1] == $past(applGain_r[1]);
  endproperty
  a_store_only: assert property (p_store_only) else $error("Gain changed without commit.");
  // The analogue stream must be refused while the microphones own the audio input.
  property p_analog_blocked;
    @(posedge clock) disable iff (!rst_n) pdmEnable_r |-> !analogReady;
  endproperty
  a_analog_blocked: assert property (p_analog_blocked) else $error("Analogue taken while on.");
  // A pair is handed on only just after a low-phase sample closed the frame.
  property p_frame_close;
    @(posedge clock) disable iff (!rst_n) frameDone_r |-> !pdmBitClock && frameCnt_r == 0;
  endproperty
  a_frame_close: assert property (p_frame_close) else $error("Pair handed on mid-frame.");
endmodule : stereo_pdm_mic_input

// [pdm_mic_pair_model.sv]
// Model of two PDM microphones sharing one data line, each sending a fixed bit.
// Assumes the receiver drives the bit clock; the line has no pull resistor.
`timescale 1ns/1ps
module pdm_mic_pair_model #(
  parameter logic LEFT_BIT = 1'b1,
  parameter logic RIGHT_BIT = 1'b0
) (
  // Bit clock from the receiver.
  input wire logic pdmBitClock,
  // Shared data line.
  output wire dataLine
);
  // Each microphone floats the line in the other's phase, so a late sample reads the other microphone's bit.
  assign dataLine = pdmBitClock ? LEFT_BIT : 1'bz;
  assign dataLine = !pdmBitClock ? RIGHT_BIT : 1'bz;
endmodule : pdm_mic_pair_model

// [stereo_pdm_mic_input_tb_top.sv]
// Self-checking bench of the stereo PDM microphone input.
// Assumes the design package; pin A carries left ones, pin B carries right ones.
`timescale 1ns/1ps
module stereo_pdm_mic_input_tb_top;
  import pdm_mic_pkg::*;
  // Eight cycles a phase gives the 80 ns bit clock.
  localparam int HALF_TB = 8;
  localparam int LIMIT = 80000;
  typedef struct packed {
    logic pinSel;
    logic leftEn;
    logic rightEn;
    gain_code_t gainL;
    gain_code_t gainR;
    logic [31:0] expWord;
  } row_t;
  logic clock, rst_n, psel, penable, pwrite, analogValid, audioReady;
  logic [ADDR_W-1:0] paddr;
  logic [31:0] pwdata, prdata, rd, w;
  logic pready, pslverr, err, pdmBitClock, analogReady, audioValid;
  wire pdmDataPinA, pdmDataPinB;
  stereo_sample_t analogSample, audioSample;
  int error_cnt, cmp_count, cycles, pops, highs;
  row_t rows [6];

  stereo_pdm_mic_input #(.HALF(HALF_TB), .DEPTH(FIFO_DEPTH)) DUT (
    .clock(clock), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pdmDataPinA(pdmDataPinA), .pdmDataPinB(pdmDataPinB), .pdmBitClock(pdmBitClock),
    .analogValid(analogValid), .analogReady(analogReady), .analogSample(analogSample),
    .audioValid(audioValid), .audioReady(audioReady), .audioSample(audioSample));
  // Inverted patterns on the two pins make a wrong pin choice visible.
  pdm_mic_pair_model #(.LEFT_BIT(1'b1), .RIGHT_BIT(1'b0)) micA (
    .pdmBitClock(pdmBitClock), .dataLine(pdmDataPinA));
  pdm_mic_pair_model #(.LEFT_BIT(1'b0), .RIGHT_BIT(1'b1)) micB (
    .pdmBitClock(pdmBitClock), .dataLine(pdmDataPinB));

  // System clock.
  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end

  // A hang counts as a mismatch and closes the run.
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      error_cnt++;
      tally_and_finish();
    end
  end

  task automatic chkWord(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chkWord

  // One APB transfer; the request holds until pready is seen at an edge.
  task automatic apb(input logic wr, input logic [ADDR_W-1:0] a, input logic [31:0] d);
    @(posedge clock);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    do @(posedge clock); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic getPair();
    do @(posedge clock); while (audioValid !== 1'b1 || audioReady !== 1'b1);
    w = audioSample;
  endtask : getPair

  task automatic tally_and_finish();
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : tally_and_finish

  // Main sequence: reset values, analogue path, reserved rate, table rows, then edge cases.
  initial begin
    rows[0] = '{1'b0, 1'b1, 1'b1, 8'hC0, 8'hC0, 32'h4000_C000};
    rows[1] = '{1'b1, 1'b1, 1'b1, 8'hC0, 8'hC0, 32'hC000_4000};
    rows[2] = '{1'b0, 1'b1, 1'b0, 8'hC0, 8'hC0, 32'h4000_0000};
    rows[3] = '{1'b0, 1'b0, 1'b1, 8'hC0, 8'hC0, 32'h0000_C000};
    rows[4] = '{1'b0, 1'b1, 1'b1, 8'hB0, 8'h00, 32'h2000_0000};
    rows[5] = '{1'b1, 1'b1, 1'b1, 8'hFF, 8'hEF, 32'h8000_7FFF};
    {error_cnt, cmp_count, cycles} = '0;
    {psel, penable, pwrite, analogValid} = '0;
    paddr = '0;
    pwdata = '0;
    analogSample = '0;
    audioReady = 1'b1;
    rst_n = 1'b0;
    repeat (3) @(posedge clock);
    rst_n <= 1'b1;
    apb(1'b0, ADDR_OVERSAMPLE, 32'h0);
    chkWord(rd, 32'h1);
    apb(1'b0, ADDR_VOL_LEFT, 32'h0);
    chkWord(rd, 32'hC0);
    apb(1'b0, ADDR_VOL_RIGHT, 32'h0);
    chkWord(rd, 32'hC0);
    apb(1'b0, ADDR_IF_CTRL, 32'h0);
    chkWord(rd, 32'h0);
    apb(1'b1, 8'h04, 32'hFFFF_FFFF);
    chkWord({31'h0, err}, 32'h1);
    // With the interface off the analogue stream feeds the audio path.
    analogSample <= 32'h1234_ABCD;
    analogValid <= 1'b1;
    do @(posedge clock); while (analogReady !== 1'b1);
    analogValid <= 1'b0;
    getPair();
    chkWord(w, 32'h1234_ABCD);
    apb(1'b1, ADDR_CLK_PIN, 32'h1);
    apb(1'b1, ADDR_POWER_SIX, 32'h3);
    apb(1'b1, ADDR_IF_CTRL, 32'h1000);
    // The enable lands at the access edge, so the ready flag is looked at one edge later.
    @(posedge clock);
    chkWord({31'h0, analogReady}, 32'h0);
    // Reserved oversample value yields no samples while the bit clock runs.
    pops = 0;
    repeat (2000) begin
      @(posedge clock);
      if (audioValid !== 1'b0) pops++;
    end
    chkWord(pops, 32'h0);
    // Wait for a low phase first so that counting starts right at a rising edge.
    do @(posedge clock); while (pdmBitClock !== 1'b0);
    do @(posedge clock); while (pdmBitClock !== 1'b1);
    pops = 0;
    do begin
      @(posedge clock);
      pops++;
    end while (pdmBitClock !== 1'b0);
    do begin
      @(posedge clock);
      pops++;
    end while (pdmBitClock !== 1'b1);
    chkWord(pops, 2 * HALF_TB);
    apb(1'b1, ADDR_OVERSAMPLE, 32'h0);
    // Two pairs after a change may mix old and new settings, so they are skipped.
    foreach (rows[i]) begin
      apb(1'b1, ADDR_IF_CTRL, {19'h0, 1'b1, rows[i].pinSel, 11'h0});
      apb(1'b1, ADDR_POWER_SIX, {30'h0, rows[i].leftEn, rows[i].rightEn});
      apb(1'b1, ADDR_VOL_LEFT, {24'h0, rows[i].gainL});
      apb(1'b1, ADDR_VOL_RIGHT, {23'h0, 1'b1, rows[i].gainR});
      repeat (3) getPair();
      chkWord(w, rows[i].expWord);
    end
    // A stored code waits for the commit, which then moves both channels.
    apb(1'b1, ADDR_VOL_LEFT, 32'hC0);
    repeat (3) getPair();
    chkWord(w, 32'h8000_7FFF);
    apb(1'b1, ADDR_VOL_RIGHT, 32'h1C0);
    repeat (3) getPair();
    chkWord(w, 32'hC000_4000);
    apb(1'b0, ADDR_VOL_LEFT, 32'h0);
    chkWord(rd, 32'hC0);
    // Stalled sink: the buffer fills, then overflows into the status flag.
    audioReady <= 1'b0;
    repeat (20 * 128 * HALF_TB) @(posedge clock);
    apb(1'b0, ADDR_STATUS, 32'h0);
    chkWord({31'h0, rd[ST_OVERRUN_BIT]}, 32'h1);
    apb(1'b1, ADDR_IF_CTRL, 32'h0);
    repeat (2) @(posedge clock);
    audioReady <= 1'b1;
    pops = 0;
    highs = 0;
    repeat (60) begin
      @(posedge clock);
      if (audioValid === 1'b1 && audioReady === 1'b1) pops++;
      if (pdmBitClock !== 1'b0) highs++;
    end
    chkWord(pops, FIFO_DEPTH);
    chkWord(highs, 32'h0);
    apb(1'b1, ADDR_STATUS, 32'h1);
    apb(1'b0, ADDR_STATUS, 32'h0);
    chkWord(rd, 32'h2);
    // A second reset mid-run brings back the reset values of written registers.
    rst_n <= 1'b0;
    repeat (3) @(posedge clock);
    rst_n <= 1'b1;
    chkWord({31'h0, pdmBitClock}, 32'h0);
    apb(1'b0, ADDR_OVERSAMPLE, 32'h0);
    chkWord(rd, 32'h1);
    apb(1'b0, ADDR_POWER_SIX, 32'h0);
    chkWord(rd, 32'h0);
    tally_and_finish();
  end
endmodule : stereo_pdm_mic_input_tb_top
